// *** verilog/config_mode_serial_port.sv ***
// Purpose: configuration-mode serial port, key entry and command replies
// Assumes: bus_pulse_in is asynchronous, AHB-Lite register slave
// Notes:   zero-wait bus, responses always OKAY
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module config_mode_serial_port
    import config_serial_pkg::*;
#(
    parameter int PHASE1_CYCLES = PHASE1_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link
    input  wire logic        bus_pulse_in,
    output logic             tx_current_out,
    // device control
    output logic             chain_output_enable,
    output logic             sync_pulse,
    output logic             autozero_force_off,
    output logic             config_mode,
    output logic             restart_pulse
);
    typedef enum logic [3:0] {
        ST_PHASE1 = 4'b0001,
        ST_CONFIG = 4'b0010,
        ST_EXIT   = 4'b0100,
        ST_NORMAL = 4'b1000
    } mode_t;

    // ****************************************
    // link halves
    // ****************************************
    serial_link_if lnk ();

    pulse_frame_rx #(.MAX_LEN(16)) u_rx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pulse_in(bus_pulse_in),
        .lnk     (lnk.rx_end)
    );

    manchester_tx u_tx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lnk     (lnk.tx_end),
        .tx_line (tx_current_out)
    );

    // ****************************************
    // state
    // ****************************************
    mode_t       state, next_state;
    logic [31:0] timer, next_timer;
    logic [7:0]  cfg_mem [16];
    logic        mem_we;
    logic        sync_mode, next_sync_mode;
    logic [3:0]  sel, next_sel;
    logic        par_err, next_par_err, frm_err, next_frm_err;
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic        next_sync_pulse, next_restart;
    logic        par_ev;

    logic        c_rw, par_ok, is_key, is_cmd, is_exit, lock;
    logic [3:0]  c_addr;
    logic [7:0]  c_data, readback;
    logic        addr_phase, clr_wr;

    assign c_rw    = lnk.frame_bits[0];
    assign c_addr  = lnk.frame_bits[4:1];
    assign c_data  = lnk.frame_bits[12:5];
    assign par_ok  = ~^lnk.frame_bits[13:0];
    assign is_key  = lnk.frame_valid && lnk.frame_len == KEY_LEN &&
                     lnk.frame_bits == ENTRY_KEY;
    assign is_cmd  = lnk.frame_valid && lnk.frame_len == CMD_LEN;
    assign is_exit = !c_rw && c_addr == EXIT_ADDR && c_data == EXIT_DATA;
    assign lock    = cfg_mem[THIRD_REG][LOCK_BIT];
    assign readback = (c_rw || lock || is_exit) ?
                      (is_exit ? c_data : cfg_mem[c_addr]) : c_data;

    assign chain_output_enable = cfg_mem[THIRD_REG][CHAIN_OUTPUT_ENABLE_BIT];
    assign config_mode        = state == ST_CONFIG || state == ST_EXIT;
    assign autozero_force_off = config_mode;

    // ****************************************
    // mode sequencer
    // ****************************************
    always_comb begin
        next_state     = state;
        next_timer     = timer;
        next_restart   = 1'b0;
        next_sync_pulse = 1'b0;
        lnk.tx_load    = 1'b0;
        lnk.tx_payload = 16'h0000;
        mem_we         = 1'b0;
        par_ev         = 1'b0;
        unique case (state)
            ST_PHASE1: begin
                next_timer = timer + 32'h1;
                if (is_key) begin
                    next_state = ST_CONFIG;
                    lnk.tx_load = 1'b1;
                    lnk.tx_payload = build_reply(SV_OK, THIRD_REG,
                        cfg_mem[THIRD_REG]);
                end else if (timer == 32'(PHASE1_CYCLES - 1)) begin
                    next_state = ST_NORMAL;
                end
            end
            ST_CONFIG: begin
                if (is_cmd && !lnk.tx_busy) begin
                    lnk.tx_load = 1'b1;
                    if (!par_ok) begin
                        par_ev = 1'b1;
                        lnk.tx_payload = build_reply(SV_ERR, 4'h0,
                            8'h00);
                    end else begin
                        mem_we = !c_rw && !lock && !is_exit;
                        lnk.tx_payload = build_reply(SV_OK, c_addr,
                            readback);
                        if (is_exit)
                            next_state = ST_EXIT;
                    end
                end
            end
            ST_EXIT: begin
                if (!lnk.tx_busy) begin
                    next_state = ST_PHASE1;
                    next_timer = 32'h0;
                    next_restart = 1'b1;
                end
            end
            ST_NORMAL: begin
                next_sync_pulse = lnk.pulse_seen && sync_mode;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_PHASE1;
            timer <= 32'h0;
            sync_pulse <= 1'b0;
            restart_pulse <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            sync_pulse <= next_sync_pulse;
            restart_pulse <= next_restart;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++)
                cfg_mem[i] <= 8'h00;
        end else if (mem_we) begin
            cfg_mem[c_addr] <= c_data;
        end
    end

    // ****************************************
    // ahb-lite register slave
    // ****************************************
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && htrans[1] && hready;
    assign clr_wr     = wr_pend && wr_addr == OFS_STATUS;

    always_comb begin
        next_wr_pend   = addr_phase && hwrite;
        next_wr_addr   = haddr[7:0];
        next_sync_mode = sync_mode;
        next_sel       = sel;
        next_hrdata    = hrdata;
        if (wr_pend && wr_addr == OFS_CTRL)
            next_sync_mode = hwdata[0];
        if (wr_pend && wr_addr == OFS_SEL)
            next_sel = hwdata[3:0];
        next_par_err = (par_err && !(clr_wr && hwdata[ST_PAR_BIT])) ||
                       par_ev;
        next_frm_err = (frm_err && !(clr_wr && hwdata[ST_FRM_BIT])) ||
                       lnk.framing_err;
        if (addr_phase && !hwrite) begin
            next_hrdata = 32'h0;
            case (haddr[7:0])
                OFS_CTRL:   next_hrdata[0] = sync_mode;
                OFS_STATUS: begin
                    next_hrdata[ST_CFG_BIT] = config_mode;
                    next_hrdata[ST_PH1_BIT] = state == ST_PHASE1;
                    next_hrdata[ST_PAR_BIT] = par_err;
                    next_hrdata[ST_FRM_BIT] = frm_err;
                end
                OFS_SEL:    next_hrdata[3:0] = sel;
                OFS_DATA:   next_hrdata[7:0] = cfg_mem[sel];
                default:    next_hrdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            sync_mode <= 1'b0;
            sel <= 4'h0;
            par_err <= 1'b0;
            frm_err <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            sync_mode <= next_sync_mode;
            sel <= next_sel;
            par_err <= next_par_err;
            frm_err <= next_frm_err;
            hrdata <= next_hrdata;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    localparam int EXIT_WAIT_MAX = 2 * int'(TX_BITS) * int'(TX_HALF_CYC) + 8;

    logic [11:0] exit_cnt, next_exit_cnt;

    // cycles spent waiting for the exit reply to drain
    always_comb begin
        next_exit_cnt = 12'h000;
        if (state == ST_EXIT && exit_cnt != 12'hfff)
            next_exit_cnt = exit_cnt + 12'h001;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            exit_cnt <= 12'h000;
        else
            exit_cnt <= next_exit_cnt;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence key_seen;
        state == ST_PHASE1 && is_key;
    endsequence
    sequence exit_cmd;
        state == ST_CONFIG && is_cmd && !lnk.tx_busy && par_ok && is_exit;
    endsequence
    sequence exit_wait_over;
        state == ST_EXIT && !lnk.tx_busy;
    endsequence

    AST_KEY_ENTRY: assert property (key_seen |-> lnk.tx_load &&
        lnk.tx_payload[14:11] == THIRD_REG ##1 state == ST_CONFIG)
        else $error("key did not enter configuration mode");
    AST_ENTRY_LOCK: assert property (key_seen |->
        lnk.tx_payload[10+LOCK_BIT-7] == lock)
        else $error("entry reply lacks lock bit");
    AST_LEN_ONLY: assert property (state == ST_CONFIG &&
        lnk.frame_valid && lnk.frame_len != CMD_LEN |-> !lnk.tx_load)
        else $error("non-command length answered");
    AST_EVEN_PAR: assert property (lnk.tx_load |->
        ^lnk.tx_payload == 1'b0)
        else $error("reply parity odd");
    AST_SV_OK: assert property (state == ST_CONFIG && is_cmd &&
        !lnk.tx_busy && par_ok |-> lnk.tx_payload[2:0] == SV_OK)
        else $error("state vector not 101");
    AST_BAD_PAR: assert property (state == ST_CONFIG && is_cmd &&
        !lnk.tx_busy && !par_ok |-> lnk.tx_load && !mem_we &&
        lnk.tx_payload[14:0] == {12'h000, SV_ERR})
        else $error("parity failure handled wrongly");
    AST_WRITE_BACK: assert property (mem_we |-> lnk.tx_load &&
        lnk.tx_payload[10:3] == c_data ##1 cfg_mem[$past(c_addr)] ==
        $past(c_data))
        else $error("write readback mismatch");
    AST_EXIT: assert property (exit_cmd |=> state == ST_EXIT)
        else $error("exit command did not enter exit wait");
    AST_EXIT_DONE: assert property (exit_wait_over |=>
        restart_pulse && state == ST_PHASE1)
        else $error("exit did not restart phase one");
    AST_EXIT_WAIT: assert property (exit_cnt <= 12'(EXIT_WAIT_MAX))
        else $error("exit wait outlasted one reply");
    AST_NO_SYNC_CFG: assert property (config_mode |->
        !sync_pulse && autozero_force_off)
        else $error("sync or auto-zero active in configuration");
    AST_ASYNC_IGN: assert property (!sync_mode |=> !sync_pulse)
        else $error("pulse passed in asynchronous mode");
endmodule

// *** verilog/config_serial_pkg.sv ***
// Purpose: shared constants for the configuration-mode serial port
// Assumes: 50 MHz core clock
// Notes:   times in ns or us, cycle counts derived below
package config_serial_pkg;
    localparam int CLK_NS        = 20;
    // ****************************************
    // link timing
    // ****************************************
    localparam int PULSE_MIN_NS  = 20;
    localparam int PULSE_THR_NS  = 80;
    localparam int PULSE_MAX_NS  = 150;
    localparam int GAP_NS        = 1000;
    localparam int TX_HALF_NS    = 1000;
    localparam int PHASE1_US     = 1000;
    localparam logic [7:0] PULSE_MIN_CYC =
        8'((PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] PULSE_THR_CYC =
        8'((PULSE_THR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] PULSE_MAX_CYC = 8'(PULSE_MAX_NS / CLK_NS);
    localparam logic [7:0] GAP_CYC = 8'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] TX_HALF_CYC   = 8'(TX_HALF_NS / CLK_NS);
    localparam int PHASE1_CYC    = PHASE1_US * 1000 / CLK_NS;
    // ****************************************
    // frames
    // ****************************************
    localparam logic [15:0] ENTRY_KEY = 16'h5a5a;
    localparam logic [4:0]  KEY_LEN   = 5'h10;
    localparam logic [4:0]  CMD_LEN   = 5'h0e;
    localparam logic [4:0]  TX_BITS   = 5'h12;
    localparam logic [1:0]  START_LSB_FIRST = 2'h1;
    localparam logic [2:0]  SV_OK     = 3'h5;
    localparam logic [2:0]  SV_ERR    = 3'h6;
    localparam logic [3:0]  EXIT_ADDR = 4'ha;
    localparam logic [7:0]  EXIT_DATA = 8'h80;
    localparam logic [3:0]  THIRD_REG = 4'h2;
    localparam int LOCK_BIT  = 7;
    localparam int CHAIN_OUTPUT_ENABLE_BIT  = 4;
    // ****************************************
    // bus registers
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SEL    = 8'h08;
    localparam logic [7:0] OFS_DATA   = 8'h0c;
    localparam int ST_CFG_BIT   = 0;
    localparam int ST_PH1_BIT   = 1;
    localparam int ST_PAR_BIT   = 2;
    localparam int ST_FRM_BIT   = 3;

    function automatic logic [15:0] build_reply(logic [2:0] sv,
        logic [3:0] addr, logic [7:0] data);
        build_reply = {^{addr, data, sv}, addr, data, sv};
    endfunction
endpackage

// *** verilog/serial_link_if.sv ***
// Purpose: carries frames between the port core and its link halves
// Assumes: one clock domain
// Notes:   none
`timescale 1ns/100ps
interface serial_link_if;
    logic        frame_valid;
    logic [15:0] frame_bits;
    logic [4:0]  frame_len;
    logic        framing_err;
    logic        pulse_seen;
    logic        tx_load;
    logic [15:0] tx_payload;
    logic        tx_busy;
    modport rx_end (output frame_valid, frame_bits, frame_len,
                    output framing_err, pulse_seen);
    modport tx_end (input tx_load, tx_payload, output tx_busy);
    modport core   (input frame_valid, frame_bits, frame_len,
                    input framing_err, pulse_seen, tx_busy,
                    output tx_load, tx_payload);
endinterface

// *** verilog/pulse_frame_rx.sv ***
// Purpose: pulse-duration decoder for the supply-pin command link
// Assumes: pulse_in is the bus_positive_pin over bus_negative_pin level
// Notes:   a frame ends after an idle gap
`timescale 1ns/100ps
module pulse_frame_rx
    import config_serial_pkg::*;
#(
    parameter int MAX_LEN = 16
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link
    input wire logic pulse_in,
    serial_link_if.rx_end lnk
);
    logic       s1, s2, lvl;
    logic [7:0] high_cnt, next_high_cnt, gap_cnt, next_gap_cnt;
    logic [15:0] bits, next_bits;
    logic [4:0] len, next_len;
    logic       bad, next_bad, next_valid, next_ferr, next_seen;

    always_comb begin
        next_high_cnt = high_cnt;
        next_gap_cnt  = gap_cnt;
        next_bits     = bits;
        next_len      = len;
        next_bad      = bad;
        next_valid    = 1'b0;
        next_ferr     = 1'b0;
        next_seen     = 1'b0;
        if (s2) begin
            next_gap_cnt = 8'h00;
            if (high_cnt != 8'hff)
                next_high_cnt = high_cnt + 8'h01;
        end else if (lvl) begin
            next_high_cnt = 8'h00;
            if (high_cnt < PULSE_MIN_CYC || high_cnt > PULSE_MAX_CYC ||
                len >= 5'(MAX_LEN)) begin
                next_bad = 1'b1;
            end else begin
                next_bits[len[3:0]] = (high_cnt >= PULSE_THR_CYC);
                next_len  = len + 5'h01;
                next_seen = 1'b1;
            end
        end else if (len != 5'h00 || bad) begin
            next_gap_cnt = gap_cnt + 8'h01;
            if (gap_cnt == GAP_CYC - 8'h01) begin
                next_valid   = ~bad;
                next_ferr    = bad;
                next_bits    = 16'h0000;
                next_len     = 5'h00;
                next_bad     = 1'b0;
                next_gap_cnt = 8'h00;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            lvl <= 1'b0;
            high_cnt <= 8'h00;
            gap_cnt <= 8'h00;
            bits <= 16'h0000;
            len <= 5'h00;
            bad <= 1'b0;
            lnk.frame_valid <= 1'b0;
            lnk.framing_err <= 1'b0;
            lnk.pulse_seen <= 1'b0;
            lnk.frame_bits <= 16'h0000;
            lnk.frame_len <= 5'h00;
        end else begin
            s1 <= pulse_in;
            s2 <= s1;
            lvl <= s2;
            high_cnt <= next_high_cnt;
            gap_cnt <= next_gap_cnt;
            bits <= next_bits;
            len <= next_len;
            bad <= next_bad;
            lnk.frame_valid <= next_valid;
            lnk.framing_err <= next_ferr;
            lnk.pulse_seen <= next_seen;
            if (next_valid) begin
                lnk.frame_bits <= bits;
                lnk.frame_len <= len;
            end
        end
    end
endmodule

// *** verilog/manchester_tx.sv ***
// Purpose: Manchester-1 current-mode reply sender
// Assumes: load only while not busy
// Notes:   a one is sent low then high, idle level is low
`timescale 1ns/100ps
module manchester_tx
    import config_serial_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link
    serial_link_if.tx_end lnk,
    output logic tx_line
);
    logic [17:0] sh, next_sh;
    logic [4:0]  left, next_left;
    logic [7:0]  cnt, next_cnt;
    logic        half, next_half, busy, next_busy, next_line;

    assign lnk.tx_busy = busy;

    always_comb begin
        next_sh = sh;
        next_left = left;
        next_cnt = cnt;
        next_half = half;
        next_busy = busy;
        next_line = tx_line;
        if (!busy) begin
            if (lnk.tx_load) begin
                next_sh   = {lnk.tx_payload, START_LSB_FIRST};
                next_left = TX_BITS;
                next_cnt  = 8'h00;
                next_half = 1'b0;
                next_busy = 1'b1;
                next_line = ~START_LSB_FIRST[0];
            end
        end else if (cnt == TX_HALF_CYC - 8'h01) begin
            next_cnt = 8'h00;
            if (!half) begin
                next_half = 1'b1;
                next_line = sh[0];
            end else begin
                next_half = 1'b0;
                next_sh   = {1'b0, sh[17:1]};
                next_left = left - 5'h01;
                next_busy = (left != 5'h01);
                next_line = (left != 5'h01) & ~sh[1];
            end
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh <= 18'h00000;
            left <= 5'h00;
            cnt <= 8'h00;
            half <= 1'b0;
            busy <= 1'b0;
            tx_line <= 1'b0;
        end else begin
            sh <= next_sh;
            left <= next_left;
            cnt <= next_cnt;
            half <= next_half;
            busy <= next_busy;
            tx_line <= next_line;
        end
    end

    AST_TX_START: assert property (@(posedge hclk) disable iff (!hresetn)
        (lnk.tx_load && !busy) |=> busy && !tx_line)
        else $error("reply did not open with start bit one");
endmodule

// *** bench/cfg_host_model.sv ***
// Purpose: test controller model for the supply-pin link
// Assumes: link idle low between frames
// Notes:   reply bits read in the second half-bit
`timescale 1ns/100ps
module cfg_host_model (
    // clock
    input  wire logic hclk,
    // link
    output logic      pulse,
    input  wire logic tx_line
);
    initial pulse = 1'b0;
    // 40 ns or w1 ns pulse per 160 ns slot (w1 + 60 ns slot when w1 is over 100 ns), lsb first
    task automatic send(input logic [15:0] b, input int n, input int w1);
        int hi;
        #7ns;
        for (int i = 0; i < n; i++) begin
            hi = b[i] ? w1 : 40;
            pulse = 1'b1;
            #(hi * 1ns);
            pulse = 1'b0;
            #((hi > 100 ? 60 : 160 - hi) * 1ns);
        end
        #1300ns;
    endtask
    // wait for first rise, then one sample per bit
    task automatic recv(output logic [15:0] p, output logic ok);
        logic [17:0] f;
        int          t;
        t = 0;
        while (tx_line !== 1'b1 && t < 4000) begin
            @(negedge hclk);
            t++;
        end
        repeat (25) @(negedge hclk);
        for (int k = 0; k < 18; k++) begin
            f[k] = tx_line;
            repeat (100) @(negedge hclk);
        end
        ok = t < 4000 && f[1:0] === 2'b01;
        p = f[17:2];
    endtask
endmodule

// *** bench/config_mode_serial_port_tb_top.sv ***
// Purpose: self-checking bench for the config-mode serial port
// Assumes: host model drives the supply-pin pulses
// Notes:   phase one shortened to P1 cycles
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module config_mode_serial_port_tb_top;
    import config_serial_pkg::*;
    localparam int P1 = 2000;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        pulse, tx, coe, syncp, azoff, cfg, rst_p, rdy, hresp, ok;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] rep;
    logic [3:0]  a;
    logic [7:0]  d;
    int          n_fail = 0, compares = 0, seed = 52, nsync = 0, nrst = 0;
    config_mode_serial_port #(
        .PHASE1_CYCLES(P1)
    ) config_mode_serial_port_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
        .bus_pulse_in(pulse), .tx_current_out(tx),
        .chain_output_enable(coe), .sync_pulse(syncp),
        .autozero_force_off(azoff), .config_mode(cfg),
        .restart_pulse(rst_p)
    );
    cfg_host_model cfg_host_model_inst (
        .hclk(hclk), .pulse(pulse), .tx_line(tx)
    );
    function automatic logic [15:0] exp_rep(logic [2:0] sv, logic [3:0] ad,
        logic [7:0] dt);
        return {^{ad, dt, sv}, ad, dt, sv};
    endfunction
    function automatic logic [15:0] cmd(logic rw, logic [3:0] ad,
        logic [7:0] dt, logic bad);
        return {2'h0, ^{dt, ad, rw, bad}, dt, ad, rw};
    endfunction
    // one single ahb-lite word transfer
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, ad};
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic cmd_chk(input logic [15:0] c, input logic [15:0] e);
        cfg_host_model_inst.send(c, 14, 100);
        cfg_host_model_inst.recv(rep, ok);
        `CHK(ok, 1'b1)
        `CHK(rep, e)
    endtask
    task automatic complete_run;
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        forever #10 hclk = ~hclk;
    end
    always @(negedge hclk) begin
        nsync += (syncp === 1'b1);
        nrst += (rst_p === 1'b1);
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK({hresp, rd}, {1'b0, 32'h2})
        bus(1'b0, 8'h40, 32'h0, rd);
        `CHK(rd, 32'h0)
        `CHK(coe, 1'b0)
        cfg_host_model_inst.send(16'ha5a5, 16, 100);
        `CHK(cfg, 1'b0)
        cfg_host_model_inst.send(cmd(1'b1, 4'h2, 8'h0, 1'b0), 14, 100);
        `CHK(cfg, 1'b0)
        cfg_host_model_inst.send(ENTRY_KEY, 16, 100);
        cfg_host_model_inst.recv(rep, ok);
        `CHK(ok, 1'b1)
        `CHK(rep, exp_rep(3'h5, 4'h2, 8'h0))
        `CHK({cfg, azoff}, 2'b11)
        $display("test entry done");
        for (int i = 0; i < 4; i++) begin
            a = {1'b0, 3'($random(seed))};
            d = 8'($random(seed));
            if (a == 4'h2) a = 4'h6;
            if (i == 0) d = 8'hff;
            cmd_chk(cmd(1'b0, a, d, 1'b0), exp_rep(3'h5, a, d));
            cmd_chk(cmd(1'b1, a, ~d, 1'b0), exp_rep(3'h5, a, d));
            bus(1'b1, OFS_SEL, {28'h0, a}, rd);
            bus(1'b0, OFS_DATA, 32'h0, rd);
            `CHK(rd, {24'h0, d})
        end
        cmd_chk(cmd(1'b0, 4'h2, 8'h10, 1'b0),
            exp_rep(3'h5, 4'h2, 8'h10));
        `CHK(coe, 1'b1)
        cmd_chk(cmd(1'b0, 4'h2, 8'h90, 1'b0),
            exp_rep(3'h5, 4'h2, 8'h90));
        cmd_chk(cmd(1'b0, a, ~d, 1'b0), exp_rep(3'h5, a, d));
        $display("test rw done");
        cmd_chk(cmd(1'b0, a, 8'h3c, 1'b1), exp_rep(3'h6, 4'h0, 8'h0));
        bus(1'b0, OFS_DATA, 32'h0, rd);
        `CHK(rd, {24'h0, d})
        cfg_host_model_inst.send(16'h3fff, 14, 300);
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd[3:2], 2'b11)
        bus(1'b1, OFS_STATUS, 32'hc, rd);
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd[3:2], 2'b00)
        $display("test errors done");
        cfg_host_model_inst.send(cmd(1'b0, 4'ha, 8'h80, 1'b0), 14, 100);
        cfg_host_model_inst.recv(rep, ok);
        `CHK({rep[14:11], rep[2:0]}, 7'h55)
        `CHK(cfg, 1'b0)
        `CHK(nrst, 1)
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        `CHK(rd[1:0], 2'b10)
        $display("test exit done");
        repeat (P1 + 100) @(posedge hclk);
        cfg_host_model_inst.send(ENTRY_KEY, 16, 100);
        `CHK(nsync, 0)
        bus(1'b1, OFS_CTRL, 32'h1, rd);
        cfg_host_model_inst.send(ENTRY_KEY, 16, 100);
        `CHK(nsync, 16)
        `CHK(cfg, 1'b0)
        $display("test sync done");
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        n_fail++;
        complete_run();
    end
endmodule
